// *** engine_peer_model.sv ***
`timescale 1ns/1ps
// ***************************************************************
// serial engine stand-in
// ***************************************************************
module engine_peer_model
	import serial_port_cmd_pkg::*;
(
	input  wire logic                             clock,
	input  wire logic                             rst_b,
	input  wire serial_port_cmd_pkg::engine_cmd_s engineCmd,
	input  wire logic                             busy,
	input  wire logic [31:0]                      flagReq,
	input  wire logic                             charReq,
	output serial_port_cmd_pkg::engine_ev_s       engineEv
);
	logic [1:0] tickCnt_reg;

	// a four-clock bit period keeps timeout and break runs short
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_reg <= 2'h0;
			engineEv    <= '0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 2'h1;
			engineEv.bitTick  <= (tickCnt_reg == 2'h3);
			engineEv.charRx   <= charReq;
			engineEv.setFlags <= flagReq;
			// a transmitter reset empties holder and shifter at once
			engineEv.txIdle <= !busy || engineCmd.txReset;
		end
	end
endmodule

// *** serial_port_cmd_pkg.sv ***
package serial_port_cmd_pkg;

	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_IRQ_SET  = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h0C;
	localparam logic [7:0] OFF_IRQ_VIEW = 8'h10;
	localparam logic [7:0] OFF_FLAGS    = 8'h14;
	localparam logic [7:0] OFF_RXCHAR   = 8'h18;
	localparam logic [7:0] OFF_TXCHAR   = 8'h1C;
	localparam logic [7:0] OFF_BAUD     = 8'h20;
	localparam logic [7:0] OFF_RTO      = 8'h24;
	localparam logic [7:0] OFF_GUARD    = 8'h28;
	localparam logic [7:0] OFF_FIDI     = 8'h40;
	localparam logic [7:0] OFF_NERR     = 8'h44;
	localparam logic [7:0] OFF_IRDA     = 8'h4C;
	localparam logic [7:0] OFF_MAN      = 8'h50;
	localparam logic [7:0] OFF_LINMODE  = 8'h54;
	localparam logic [7:0] OFF_LINID    = 8'h58;
	localparam logic [7:0] OFF_LINRATE  = 8'h5C;
	localparam logic [7:0] OFF_LOCK     = 8'hE4;
	localparam logic [7:0] OFF_LOCKSTAT = 8'hE8;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [31:0] RST_FIDI = 32'h00000174;
	localparam logic [31:0] RST_MAN  = 32'h30011004;

	// ***************************************************************
	// command bit positions
	// ***************************************************************
	localparam int B_RECEIVER_RESET_CMD = 2;
	localparam int B_TRANSMITTER_RESET_CMD = 3;
	localparam int B_RXON  = 4;
	localparam int B_RXOFF = 5;
	localparam int B_TXON  = 6;
	localparam int B_TXOFF = 7;
	localparam int B_FCLR  = 8;
	localparam int B_BRKB  = 9;
	localparam int B_BRKE  = 10;
	localparam int B_TOARM = 11;
	localparam int B_ADDR  = 12;
	localparam int B_ITCLR = 13;
	localparam int B_NKCLR = 14;
	localparam int B_TORST = 15;
	localparam int B_RTSON = 18;
	localparam int B_RTSOF = 19;
	localparam int B_LABT  = 20;
	localparam int B_LWAKE = 21;

	// ***************************************************************
	// mode field and status flag positions
	// ***************************************************************
	localparam logic [3:0] M_NORMAL  = 4'h0;
	localparam logic [3:0] M_HWHS    = 4'h2;
	localparam logic [3:0] M_ISO_T0  = 4'h4;
	localparam logic [3:0] M_ISO_T1  = 4'h6;
	localparam logic [3:0] M_LINMAS  = 4'hA;
	localparam logic [3:0] M_SPIMAS  = 4'hE;
	localparam logic [3:0] M_SPISLV  = 4'hF;
	localparam logic [2:0] PAR_MULTI = 3'h6;
	localparam int MODE_MSB = 3;
	localparam int PAR_LSB  = 9;
	localparam int PAR_MSB  = 11;
	localparam int TO_MSB   = 16;
	localparam int LOCK_MSB = 7;
	localparam int SRC_LSB  = 8;
	localparam int SRC_MSB  = 15;
	localparam int F_OVERRUN_FLAG   = 5;
	localparam int F_PARITY_ERROR_FLAG   = 7;
	localparam int F_TOUT   = 8;
	localparam int F_ITERATION_LIMIT_FLAG   = 10;
	localparam int F_NACK   = 13;
	localparam int F_UNDERRUN_FLAG   = 10;
	localparam int F_LINLO  = 14;
	localparam int F_LINHI  = 31;
	localparam int F_ERRLO  = 5;
	localparam int F_ERRHI  = 7;
	localparam int F_MANE   = 24;
	localparam int F_BRK    = 2;
	localparam logic [16:0] TO_ZERO = 17'h00000;
	localparam logic [16:0] TO_ONE  = 17'h00001;
	localparam logic [3:0]  GAP_BITS = 4'hC;
	localparam logic [3:0]  CHAR_BITS = 4'hA;

	// bus request carried as one bundle
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	// serial engine event inputs
	typedef struct packed {
		logic        bitTick;
		logic        charRx;
		logic        txIdle;
		logic [31:0] setFlags;
	} engine_ev_s;

	// strobes out to the engines
	typedef struct packed {
		logic rxReset;
		logic txReset;
		logic rxOn;
		logic txOn;
		logic linAbort;
		logic linWake;
		logic addrMark;
	} engine_cmd_s;

endpackage

// *** serial_port_command_and_protect.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Contract
// - lock bit blocks writes to the seven configuration registers.
// - blocked write sets violation flag and records target register offset.
// - reading the lock status register clears the violation flag.
// - lin identifier writable only in lin master mode.
// - reset strobes reset receiver or transmitter; zero bits do nothing.
// - enable works only without its disable in the same write.
// - non-spi flag clear wipes error, break and lin status flags.
// - break begins after holder and shifter empty; ignored during a break.
// - break end waits a character, then 12 idle bit periods; else ignored.
// - arm cancels timeout, clears flag, holds counter until a character.
// - restart reloads and runs timeout at once.
// - in multidrop mode the next transmitted character carries address mark.
// - iteration clear only in smart-card mode; nack clear clears nack flag.
// - rts set drives 1 in mode 2, 0 in mode 0; clear opposite.
// - lin abort strobe aborts current lin transfer.
// - lin wakeup strobe sends a wakeup on the bus.
// - spi modes use spi command layout; flag clear hits overrun, underrun.
// - spi master force-select drives select line low.
// - spi master release-select returns select line high.
// - 17-bit timeout counter loads, steps per bit, reloads per character.
module serial_port_command_and_protect (
	input  wire logic                             clock,
	input  wire logic                             rst_b,
	input  wire serial_port_cmd_pkg::bus_req_s    busReq,
	output logic [31:0]                           rdData,
	input  wire serial_port_cmd_pkg::engine_ev_s  engineEv,
	output serial_port_cmd_pkg::engine_cmd_s      engineCmd,
	output logic                                  rtsPin,
	output logic                                  breakLine,
	output logic                                  rxEnabled,
	output logic                                  txEnabled
);
	import serial_port_cmd_pkg::*;

	// ***************************************************************
	// decoding helpers
	// ***************************************************************
	function automatic logic isLocked(input logic [7:0] a);
		isLocked = (a == OFF_MODE) || (a == OFF_BAUD) || (a == OFF_RTO) ||
			(a == OFF_GUARD) || (a == OFF_FIDI) || (a == OFF_IRDA) ||
			(a == OFF_MAN);
	endfunction

	function automatic logic isSpi(input logic [3:0] m);
		isSpi = (m == M_SPIMAS) || (m == M_SPISLV);
	endfunction

	typedef enum logic [3:0] {
		BRK_IDLE = 4'b0001,
		BRK_WAIT = 4'b0010,
		BRK_ON   = 4'b0100,
		BRK_GAP  = 4'b1000
	} brk_state_e;

	logic [31:0] modeReg, baudReg, rtoReg, guardReg, fidiReg;
	logic [31:0] irdaReg, manReg, linModeReg, linIdReg;
	logic [31:0] lockReg, lockStatReg, flagsReg, irqMaskReg;
	logic [16:0] toCountReg;
	logic        toHoldReg, addrPendReg, brkStopReg;
	logic [3:0]  brkCountReg;
	brk_state_e  brkStateReg;
	logic        wrOk, lockHit, cmdWr;
	logic [31:0] cmd, clrMask, rdNext;
	logic [3:0]  modeField;

	assign modeField = modeReg[MODE_MSB:0];
	assign cmdWr     = busReq.wr && (busReq.addr == OFF_CMD);
	assign cmd       = cmdWr ? busReq.wdata : RST_ZERO;
	assign lockHit   = busReq.wr && lockReg[0] && isLocked(busReq.addr);
	assign wrOk      = busReq.wr && !lockHit;

	// ***************************************************************
	// configuration registers
	// ***************************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			modeReg    <= RST_ZERO;
			baudReg    <= RST_ZERO;
			rtoReg     <= RST_ZERO;
			guardReg   <= RST_ZERO;
			fidiReg    <= RST_FIDI;
			irdaReg    <= RST_ZERO;
			manReg     <= RST_MAN;
			linModeReg <= RST_ZERO;
			linIdReg   <= RST_ZERO;
			lockReg    <= RST_ZERO;
			irqMaskReg <= RST_ZERO;
		end else if (wrOk) begin
			unique case (busReq.addr)
				OFF_MODE:    modeReg    <= busReq.wdata;
				OFF_BAUD:    baudReg    <= busReq.wdata;
				OFF_RTO:     rtoReg     <= busReq.wdata;
				OFF_GUARD:   guardReg   <= busReq.wdata;
				OFF_FIDI:    fidiReg    <= busReq.wdata;
				OFF_IRDA:    irdaReg    <= busReq.wdata;
				OFF_MAN:     manReg     <= busReq.wdata;
				OFF_LINMODE: linModeReg <= busReq.wdata;
				OFF_LINID: begin
					// identifier is read-only outside master node
					if (modeField == M_LINMAS) begin
						linIdReg <= busReq.wdata;
					end
				end
				OFF_LOCK:    lockReg    <= busReq.wdata;
				OFF_IRQ_SET: irqMaskReg <= irqMaskReg | busReq.wdata;
				OFF_IRQ_CLR: irqMaskReg <= irqMaskReg & ~busReq.wdata;
				default: ;
			endcase
		end
	end

	// ***************************************************************
	// lock violation report
	// ***************************************************************
	// a new violation wins over the clear-on-read in the same cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lockStatReg <= RST_ZERO;
		end else if (lockHit) begin
			lockStatReg[0] <= 1'b1;
			lockStatReg[SRC_MSB:SRC_LSB] <= busReq.addr;
		end else if (busReq.rd && busReq.addr == OFF_LOCKSTAT) begin
			lockStatReg[0] <= 1'b0;
		end
	end

	// ***************************************************************
	// status flags
	// ***************************************************************
	always_comb begin
		clrMask = RST_ZERO;
		if (cmd[B_FCLR]) begin
			if (isSpi(modeField)) begin
				clrMask[F_OVERRUN_FLAG] = 1'b1;
				clrMask[F_UNDERRUN_FLAG] = 1'b1;
			end else begin
				clrMask[F_ERRHI:F_ERRLO] = 3'h7;
				clrMask[F_LINHI:F_LINLO] = '1;
				clrMask[F_MANE] = 1'b1;
				clrMask[F_BRK]  = 1'b1;
			end
		end
		if (cmd[B_ITCLR] && (modeField == M_ISO_T0 || modeField == M_ISO_T1)) begin
			clrMask[F_ITERATION_LIMIT_FLAG] = 1'b1;
		end
		if (cmd[B_NKCLR]) begin
			clrMask[F_NACK] = 1'b1;
		end
		if (cmd[B_TOARM]) begin
			clrMask[F_TOUT] = 1'b1;
		end
	end

	// engine events set flags; set beats a simultaneous clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flagsReg <= RST_ZERO;
		end else begin
			flagsReg <= (flagsReg & ~clrMask) | engineEv.setFlags |
				{23'h000000, (toCountReg == TO_ONE) && !toHoldReg &&
				engineEv.bitTick && (rtoReg[TO_MSB:0] != TO_ZERO), 8'h00};
		end
	end

	// ***************************************************************
	// receiver timeout counter
	// ***************************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			toCountReg <= TO_ZERO;
			toHoldReg  <= 1'b0;
		end else if (cmd[B_TORST]) begin
			toCountReg <= rtoReg[TO_MSB:0];
			toHoldReg  <= 1'b0;
		end else if (cmd[B_TOARM]) begin
			toCountReg <= rtoReg[TO_MSB:0];
			toHoldReg  <= 1'b1;
		end else if (engineEv.charRx) begin
			toCountReg <= rtoReg[TO_MSB:0];
			toHoldReg  <= 1'b0;
		end else if (engineEv.bitTick && !toHoldReg && toCountReg != TO_ZERO) begin
			toCountReg <= toCountReg - TO_ONE;
		end
	end

	// ***************************************************************
	// break sequencer
	// ***************************************************************
	// counts bit periods so the break spans at least one character
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			brkStateReg <= BRK_IDLE;
			brkCountReg <= 4'h0;
			brkStopReg  <= 1'b0;
		end else begin
			unique case (brkStateReg)
				BRK_IDLE: if (cmd[B_BRKB]) begin
					brkStateReg <= BRK_WAIT;
				end
				BRK_WAIT: if (engineEv.txIdle) begin
					brkStateReg <= BRK_ON;
					brkCountReg <= 4'h0;
					brkStopReg  <= cmd[B_BRKE];
				end
				BRK_ON: begin
					if (cmd[B_BRKE]) begin
						brkStopReg <= 1'b1;
					end
					if (engineEv.bitTick && brkCountReg != CHAR_BITS) begin
						brkCountReg <= brkCountReg + 4'h1;
					end
					if ((brkStopReg || cmd[B_BRKE]) && brkCountReg == CHAR_BITS) begin
						brkStateReg <= BRK_GAP;
						brkCountReg <= 4'h0;
						brkStopReg  <= 1'b0;
					end
				end
				BRK_GAP: if (engineEv.bitTick) begin
					brkCountReg <= brkCountReg + 4'h1;
					if (brkCountReg == GAP_BITS - 4'h1) begin
						brkStateReg <= BRK_IDLE;
					end
				end
			endcase
		end
	end

	// ***************************************************************
	// unit enables, rts / select line, strobes
	// ***************************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxEnabled <= 1'b0;
			txEnabled <= 1'b0;
		end else begin
			if (cmd[B_RXOFF] || cmd[B_RECEIVER_RESET_CMD]) begin
				rxEnabled <= 1'b0;
			end else if (cmd[B_RXON]) begin
				rxEnabled <= 1'b1;
			end
			if (cmd[B_TXOFF] || cmd[B_TRANSMITTER_RESET_CMD]) begin
				txEnabled <= 1'b0;
			end else if (cmd[B_TXON]) begin
				txEnabled <= 1'b1;
			end
		end
	end

	// the select pins share the rts bits; spi master is active low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rtsPin <= 1'b1;
		end else if (modeField == M_SPIMAS) begin
			if (cmd[B_RTSON]) begin
				rtsPin <= 1'b0;
			end else if (cmd[B_RTSOF]) begin
				rtsPin <= 1'b1;
			end
		end else if (!isSpi(modeField)) begin
			if (cmd[B_RTSON]) begin
				rtsPin <= (modeField == M_HWHS);
			end else if (cmd[B_RTSOF]) begin
				rtsPin <= (modeField == M_NORMAL);
			end
		end
	end

	// pending address mark is consumed by the next transmit write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addrPendReg <= 1'b0;
		end else if (cmd[B_ADDR] && modeReg[PAR_MSB:PAR_LSB] == PAR_MULTI) begin
			addrPendReg <= 1'b1;
		end else if (busReq.wr && busReq.addr == OFF_TXCHAR) begin
			addrPendReg <= 1'b0;
		end
	end

	// one-cycle pulses toward the engines; break line held while the break is on
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			engineCmd <= '0;
			breakLine <= 1'b0;
		end else begin
			engineCmd.rxReset  <= cmd[B_RECEIVER_RESET_CMD];
			engineCmd.txReset  <= cmd[B_TRANSMITTER_RESET_CMD];
			engineCmd.rxOn     <= cmd[B_RXON] && !cmd[B_RXOFF];
			engineCmd.txOn     <= cmd[B_TXON] && !cmd[B_TXOFF];
			engineCmd.linAbort <= cmd[B_LABT] && !isSpi(modeField);
			engineCmd.linWake  <= cmd[B_LWAKE] && !isSpi(modeField);
			engineCmd.addrMark <= addrPendReg && busReq.wr &&
				busReq.addr == OFF_TXCHAR;
			breakLine <= (brkStateReg == BRK_ON);
		end
	end

	// ***************************************************************
	// read port
	// ***************************************************************
	// write-only offsets and holes fall to zero
	always_comb begin
		unique case (busReq.addr)
			OFF_MODE:     rdNext = modeReg;
			OFF_BAUD:     rdNext = baudReg;
			OFF_RTO:      rdNext = rtoReg;
			OFF_GUARD:    rdNext = guardReg;
			OFF_FIDI:     rdNext = fidiReg;
			OFF_IRDA:     rdNext = irdaReg;
			OFF_MAN:      rdNext = manReg;
			OFF_LINMODE:  rdNext = linModeReg;
			OFF_LINID:    rdNext = linIdReg;
			OFF_LOCK:     rdNext = lockReg;
			OFF_LOCKSTAT: rdNext = lockStatReg;
			OFF_FLAGS:    rdNext = flagsReg;
			OFF_IRQ_VIEW: rdNext = irqMaskReg;
			default:      rdNext = RST_ZERO;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= RST_ZERO;
		end else begin
			rdData <= busReq.rd ? rdNext : RST_ZERO;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	// every check runs on the one clock and sleeps through reset
	default clocking chkClk @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// a blocked write must leave every locked register untouched
	lock_block_a: assert property (lockHit |=>
		$stable(modeReg) && $stable(baudReg) && $stable(rtoReg) &&
		$stable(guardReg) && $stable(fidiReg) && $stable(irdaReg) &&
		$stable(manReg))
		else $error("locked write got through");
	lock_flag_a: assert property (lockHit |=> lockStatReg[0])
		else $error("violation flag not set");
	lock_clear_a: assert property (busReq.rd && !lockHit &&
		busReq.addr == OFF_LOCKSTAT |=> !lockStatReg[0])
		else $error("violation flag not cleared by read");
	// a receiver reset pulse only ever follows its own strobe
	strobe_pulse_a: assert property (engineCmd.rxReset |->
		$past(cmd[B_RECEIVER_RESET_CMD]))
		else $error("strobe pulse without a strobe");
	enable_pair_a: assert property (cmd[B_TXON] && cmd[B_TXOFF] |=>
		!txEnabled)
		else $error("enable beat disable");
	spi_select_a: assert property (modeField == M_SPIMAS &&
		cmd[B_RTSON] |=> !rtsPin)
		else $error("select not forced low");
	sequence toArm_s;
		cmd[B_TOARM] && !cmd[B_TORST];
	endsequence
	// an expiry landing in the arm cycle still wins the flag
	timeout_hold_a: assert property (toArm_s |=> toHoldReg &&
		(!flagsReg[F_TOUT] || $past(engineEv.setFlags[F_TOUT]) ||
		$past(engineEv.bitTick && toCountReg == TO_ONE)))
		else $error("arm did not hold counter");
	timeout_reload_a: assert property (cmd[B_TORST] |=>
		toCountReg == $past(rtoReg[TO_MSB:0]) && !toHoldReg)
		else $error("restart did not reload");
	lin_id_a: assert property (modeField != M_LINMAS |=>
		$stable(linIdReg))
		else $error("identifier written outside master");
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
	import serial_port_cmd_pkg::*;
;
	localparam logic [31:0] CLR_MASK = 32'hFFFFC0E4;
	logic        clock;
	logic        rst_b;
	bus_req_s    busReq;
	logic [31:0] rdData;
	engine_ev_s  engineEv;
	engine_cmd_s engineCmd;
	engine_cmd_s cmdSeen;
	logic        rtsPin;
	logic        breakLine;
	logic        rxEnabled;
	logic        txEnabled;
	logic        busy;
	logic [31:0] flagReq;
	logic        charReq;
	logic [31:0] rv;
	logic [31:0] irqExp = 32'h0;
	int          errors;
	int          n_checks;
	int          seed;
	logic [7:0]  offs [0:5] = '{OFF_FIDI, OFF_MAN, OFF_MODE, OFF_LOCKSTAT,
		OFF_CMD, 8'h2C};
	logic [31:0] rsts [0:5] = '{RST_FIDI, RST_MAN, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO};
	logic [7:0]  po [0:6] = '{OFF_MODE, OFF_BAUD, OFF_RTO, OFF_GUARD,
		OFF_FIDI, OFF_IRDA, OFF_MAN};
	int          cb [0:5] = '{B_RECEIVER_RESET_CMD, B_TRANSMITTER_RESET_CMD, B_RXON, B_TXON, B_LABT,
		B_LWAKE};

	serial_port_command_and_protect DUT (
		.clock     (clock),
		.rst_b     (rst_b),
		.busReq    (busReq),
		.rdData    (rdData),
		.engineEv  (engineEv),
		.engineCmd (engineCmd),
		.rtsPin    (rtsPin),
		.breakLine (breakLine),
		.rxEnabled (rxEnabled),
		.txEnabled (txEnabled)
	);

	engine_peer_model peer (
		.clock     (clock),
		.rst_b     (rst_b),
		.engineCmd (engineCmd),
		.busy      (busy),
		.flagReq   (flagReq),
		.charReq   (charReq),
		.engineEv  (engineEv)
	);

	// ***************************************************************
	// tasks
	// ***************************************************************
	// free-running clock
	always #2 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// strobe sampled at the second edge; its pulse is caught just after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		busReq <= '{a, d, 1'b0, 1'b0};
		#1 cmdSeen = engineCmd;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
		@(posedge clock);
		busReq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1 chk(rdData & m, e);
	endtask

	task automatic fl(input logic [31:0] v);
		@(posedge clock);
		flagReq <= v;
		@(posedge clock);
		flagReq <= '0;
	endtask

	function automatic logic rtsExp(input logic [3:0] m, input logic s);
		return (m == M_HWHS) ? s : !s;
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		clock = 0; rst_b = 0; busReq = '0; busy = 0;
		flagReq = '0; charReq = 0; errors = 0; n_checks = 0; seed = 31633;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(offs[i], '1, rsts[i]);
		for (int i = 0; i < 6; i++) begin
			wr(OFF_CMD, 32'h1 << cb[i]);
			chk(cmdSeen, 7'h40 >> i);
			@(posedge clock);
			#1 chk(engineCmd, 32'h0);
		end
		chk({rxEnabled, txEnabled}, 2'b11);
		wr(OFF_CMD, 32'hF0);
		chk({cmdSeen, rxEnabled, txEnabled}, 9'h0);
		wr(OFF_CMD, 32'h0);
		chk(cmdSeen, 32'h0);
		wr(OFF_CMD, 32'h50);
		wr(OFF_CMD, 32'h4);
		chk({rxEnabled, txEnabled}, 2'b01);
		// random traffic on open registers, write-only reads as zero
		for (int i = 0; i < 8; i++) begin
			rv = $random(seed);
			wr(i[0] ? OFF_BAUD : OFF_GUARD, rv);
			rdc(i[0] ? OFF_BAUD : OFF_GUARD, '1, rv);
			wr(OFF_IRQ_SET, rv);
			irqExp = irqExp | rv;
			rdc(OFF_IRQ_SET, '1, 32'h0);
		end
		// enable set/clear pair lands in the view register
		wr(OFF_IRQ_CLR, rv);
		rdc(OFF_IRQ_CLR, '1, 32'h0);
		rdc(OFF_IRQ_VIEW, '1, irqExp & ~rv);
		// address mark only once, and only in multidrop
		wr(OFF_MODE, 32'h00000C00);
		wr(OFF_CMD, 32'h1 << B_ADDR);
		wr(OFF_TXCHAR, rv);
		chk(cmdSeen, 32'h1);
		wr(OFF_TXCHAR, rv);
		chk(cmdSeen, 32'h0);
		wr(OFF_MODE, M_NORMAL);
		wr(OFF_CMD, 32'h1 << B_ADDR);
		wr(OFF_TXCHAR, rv);
		chk(cmdSeen, 32'h0);
		// flag clearing in each layout
		fl('1);
		rdc(OFF_FLAGS, CLR_MASK | 32'h2400, CLR_MASK | 32'h2400);
		wr(OFF_CMD, 32'h1 << B_FCLR);
		rdc(OFF_FLAGS, CLR_MASK | 32'h2400, 32'h2400);
		wr(OFF_CMD, 32'h1 << B_ITCLR);
		rdc(OFF_FLAGS, 32'h0400, 32'h0400);
		wr(OFF_CMD, 32'h1 << B_NKCLR);
		rdc(OFF_FLAGS, 32'h2000, 32'h0);
		wr(OFF_MODE, M_ISO_T0);
		wr(OFF_CMD, 32'h1 << B_ITCLR);
		rdc(OFF_FLAGS, 32'h0400, 32'h0);
		fl(32'h400);
		wr(OFF_MODE, M_ISO_T1);
		wr(OFF_CMD, 32'h1 << B_ITCLR);
		rdc(OFF_FLAGS, 32'h0400, 32'h0);
		wr(OFF_MODE, M_SPISLV);
		fl('1);
		wr(OFF_CMD, 32'h1 << B_FCLR);
		rdc(OFF_FLAGS, 32'h04A0, 32'h0080);
		// lin strobes have no place in the spi layout
		wr(OFF_CMD, (32'h1 << B_LABT) | (32'h1 << B_LWAKE));
		chk(cmdSeen, 32'h0);
		// handshake pin and spi select through both strobes
		foreach (po[k]) if (k < 3) begin
			rv = (k == 0) ? M_HWHS : (k == 1) ? M_NORMAL : M_SPIMAS;
			for (int s = 0; s < 2; s++) begin
				wr(OFF_MODE, rv);
				wr(OFF_CMD, 32'h1 << (s ? B_RTSON : B_RTSOF));
				chk(rtsPin, rtsExp(rv[3:0], s[0]));
			end
		end
		// receiver timeout: hold, start on a character, restart
		wr(OFF_MODE, M_NORMAL);
		wr(OFF_RTO, 32'h3);
		wr(OFF_CMD, 32'h1 << B_TOARM);
		rdc(OFF_FLAGS, 32'h100, 32'h0);
		repeat (40) @(posedge clock);
		rdc(OFF_FLAGS, 32'h100, 32'h0);
		@(posedge clock) charReq <= 1'b1;
		@(posedge clock) charReq <= 1'b0;
		repeat (40) @(posedge clock);
		rdc(OFF_FLAGS, 32'h100, 32'h100);
		wr(OFF_CMD, 32'h1 << B_TOARM);
		wr(OFF_CMD, 32'h1 << B_TORST);
		repeat (40) @(posedge clock);
		rdc(OFF_FLAGS, 32'h100, 32'h100);
		// break waits for an empty transmitter and lasts a character
		@(posedge clock) busy <= 1'b1;
		wr(OFF_CMD, 32'h1 << B_BRKB);
		repeat (20) @(posedge clock);
		#1 chk(breakLine, 32'h0);
		@(posedge clock) busy <= 1'b0;
		repeat (8) @(posedge clock);
		#1 chk(breakLine, 32'h1);
		wr(OFF_CMD, 32'h1 << B_BRKE);
		repeat (4) @(posedge clock);
		#1 chk(breakLine, 32'h1);
		repeat (60) @(posedge clock);
		#1 chk(breakLine, 32'h0);
		// an end strobe while idle must not cut the next break short
		repeat (30) @(posedge clock);
		wr(OFF_CMD, 32'h1 << B_BRKE);
		wr(OFF_CMD, 32'h1 << B_BRKB);
		repeat (60) @(posedge clock);
		#1 chk(breakLine, 32'h1);
		wr(OFF_CMD, 32'h1 << B_BRKE);
		repeat (4) @(posedge clock);
		#1 chk(breakLine, 32'h0);
		// identifier writable only as lin master
		wr(OFF_LINID, 32'h55);
		rdc(OFF_LINID, '1, 32'h0);
		wr(OFF_MODE, M_LINMAS);
		wr(OFF_LINID, 32'h55);
		rdc(OFF_LINID, '1, 32'h55);
		// every locked register reports itself
		wr(OFF_LOCK, 32'h1);
		for (int i = 0; i < 7; i++) begin
			wr(po[i], $random(seed));
			rdc(OFF_LOCKSTAT, 32'hFF01, {po[i], 8'h01});
		end
		rdc(OFF_LOCKSTAT, 32'h1, 32'h0);
		rdc(OFF_MODE, 32'hF, M_LINMAS);
		wr(OFF_LOCK, 32'h0);
		wr(OFF_MODE, 32'h0);
		rdc(OFF_MODE, '1, 32'h0);
		print_verdict();
	end

	// watchdog at 10000 cycles, well beyond the roughly 600 cycles of the sequence
	initial begin
		#40000;
		errors++;
		print_verdict();
	end
endmodule
